// File: shared/srt_cfg.svh
// register offsets, field positions and reset values for the reload timer
// assumes a byte-addressed register port with 16-bit data
`ifndef SRT_CFG_SVH
`define SRT_CFG_SVH

// ==========================================================================
// register map
`define SRT_ADDR_W            8
`define SRT_OFF_COUNT         8'h62
`define SRT_OFF_RELOAD        8'h64
`define SRT_OFF_CONTROL       8'h66
`define SRT_OFF_IRQ           8'h68
`define SRT_OFF_BASE_DIV      8'h6A

// ==========================================================================
// control fields
`define SRT_CTL_SEL_LSB       0
`define SRT_CTL_SEL_MSB       2
`define SRT_CTL_RUN_BIT       3
`define SRT_CTL_OUT_BIT       7
`define SRT_CTL_RESET         8'h70
`define SRT_CTL_ONES          8'h70

// ==========================================================================
// interrupt register fields
`define SRT_IRQ_REQ_BIT       0
`define SRT_IRQ_EN_BIT        1
`define SRT_IRQ_PRI_LSB       2
`define SRT_IRQ_PRI_MSB       3
`define SRT_IRQ_VECTOR        16'h001A

// ==========================================================================
// base clock divider
`define SRT_DIV_RESET         8'hF0
`define SRT_DIV_ONES          8'hF0

`endif

// File: shared/srt_pkg.sv
// types shared by the reload timer modules
// assumes srt_cfg.svh is on the include path
package srt_pkg;

  // ==========================================================================
  // count clock selector codes
  typedef enum logic [2:0] {
    SRT_SEL_DIV1,
    SRT_SEL_DIV2,
    SRT_SEL_DIV4,
    SRT_SEL_DIV8,
    SRT_SEL_DIV32,
    SRT_SEL_DIV256,
    SRT_SEL_EVT_RISE,
    SRT_SEL_EVT_FALL
  } srt_sel_e;

  // ==========================================================================
  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } srt_req_s;

  // ==========================================================================
  // overflow interrupt signals toward the interrupt controller
  typedef struct packed {
    logic        request;
    logic        enable;
    logic [1:0]  priority_lvl;
    logic [15:0] vector;
  } srt_irq_s;

endpackage

// File: hw/srt_base_clock.sv
// prescaled base clock: a 4-bit reload divider on the cpu clock and a tap counter
// assumes the divider reload value is written by the timer's register port
`timescale 1ns/1ps
`include "srt_cfg.svh"
module srt_base_clock
  import srt_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // divider reload value
  input  wire logic [3:0] div_reload,
  // one-cycle strobes: base tick and its divided taps
  output logic            base_tick,
  output logic [7:0]      tap_tick
);

  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic [7:0] tap_r;
  logic [7:0] tap_nxt;
  wire        div_wrap = (div_r == 4'hF);

  // ==========================================================================
  // divider counts up to all ones then reloads, giving 1/(16-reload)
  assign div_nxt = div_wrap ? div_reload : div_r + 4'h1;
  assign tap_nxt = div_wrap ? tap_r + 8'h01 : tap_r;

  // tap k fires when the low k+1 bits of the tap counter are all ones and about to roll over
  genvar k;
  for (k = 0; k < 8; k++) begin : g_tap
    assign tap_tick[k] = div_wrap && (tap_r[k:0] == {(k+1){1'b1}});
  end
  assign base_tick = div_wrap;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_r <= 4'(`SRT_DIV_RESET);
      tap_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
      tap_r <= tap_nxt;
    end
  end

endmodule

// File: hw/srt_timer.sv
// 16-bit auto-reload timer with count clock selector, output toggle and overflow request
// assumes a single-cycle register port and an event input synchronous to clk
`timescale 1ns/1ps
`include "srt_cfg.svh"
module srt_timer
  import srt_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // register port
  input  wire srt_req_s    req,
  output logic [15:0]      rdata,
  // event input and timer output
  input  wire logic        event_input,
  output logic             timer_out,
  // overflow interrupt
  output srt_irq_s         irq
);

  // ==========================================================================
  // registers
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] reload_r;
  logic [15:0] reload_nxt;
  logic [7:0]  ctl_r;
  logic [7:0]  ctl_nxt;
  logic        req_flag_r;
  logic        req_flag_nxt;
  logic        irq_en_r;
  logic [1:0]  irq_pri_r;
  logic [3:0]  div_reload_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        timer_out_r;
  logic        evt_fall_r;
  logic        evt_prev_r;

  // ==========================================================================
  // decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  wire wr_count  = req.wr && hit(req.addr, `SRT_OFF_COUNT);
  wire wr_reload = req.wr && hit(req.addr, `SRT_OFF_RELOAD);
  wire wr_ctl    = req.wr && hit(req.addr, `SRT_OFF_CONTROL);
  wire wr_irq    = req.wr && hit(req.addr, `SRT_OFF_IRQ);
  wire wr_div    = req.wr && hit(req.addr, `SRT_OFF_BASE_DIV);

  // ==========================================================================
  // count clock
  logic       base_tick;
  logic [7:0] tap_tick;

  srt_base_clock u_base (
    .clk        (clk),
    .resetn     (resetn),
    .div_reload (div_reload_r),
    .base_tick  (base_tick),
    .tap_tick   (tap_tick)
  );

  // event level is captured on the falling edge and edge-detected on the rising one
  always_ff @(negedge clk) begin
    evt_fall_r <= event_input;
  end

  wire      evt_rise_edge = evt_fall_r && !evt_prev_r;
  wire      evt_fall_edge = !evt_fall_r && evt_prev_r;
  srt_sel_e sel;
  logic     count_tick;
  assign sel = srt_sel_e'(ctl_r[`SRT_CTL_SEL_MSB:`SRT_CTL_SEL_LSB]);

  always_comb begin
    case (sel)
      SRT_SEL_DIV1:     count_tick = base_tick;
      SRT_SEL_DIV2:     count_tick = tap_tick[0];
      SRT_SEL_DIV4:     count_tick = tap_tick[1];
      SRT_SEL_DIV8:     count_tick = tap_tick[2];
      SRT_SEL_DIV32:    count_tick = tap_tick[4];
      SRT_SEL_DIV256:   count_tick = tap_tick[7];
      SRT_SEL_EVT_RISE: count_tick = evt_rise_edge;
      SRT_SEL_EVT_FALL: count_tick = evt_fall_edge;
      default:          count_tick = 1'b0;
    endcase
  end

  // ==========================================================================
  // counter, reload and overflow
  wire running  = ctl_r[`SRT_CTL_RUN_BIT];
  wire step     = running && count_tick;
  wire overflow = step && (count_r == 16'hFFFF);

  // a software write in the same cycle as a step wins over the step
  assign count_nxt = wr_count ? req.wdata :
                     overflow ? reload_r :
                     step     ? count_r + 16'h0001 :
                                count_r;
  assign reload_nxt = (wr_count || wr_reload) ? req.wdata : reload_r;

  // write sets the new level; the toggle then applies on top of it, so an overflow
  // coinciding with a read-modify-write may lose a toggle
  wire [7:0] ctl_wr = wr_ctl ? (req.wdata[7:0] | `SRT_CTL_ONES) : ctl_r;
  assign ctl_nxt = overflow ? (ctl_wr ^ (8'h01 << `SRT_CTL_OUT_BIT)) : ctl_wr;

  // hardware set wins over software clear
  wire sw_clr_req = wr_irq && !req.wdata[`SRT_IRQ_REQ_BIT];
  assign req_flag_nxt = overflow ? 1'b1 : (sw_clr_req ? 1'b0 : req_flag_r);

  // ==========================================================================
  // read mux
  always_comb begin
    rdata_nxt = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        `SRT_OFF_COUNT:    rdata_nxt = count_r;
        `SRT_OFF_RELOAD:   rdata_nxt = reload_r;
        `SRT_OFF_CONTROL:  rdata_nxt = {8'h00, ctl_r | `SRT_CTL_ONES};
        `SRT_OFF_IRQ:      rdata_nxt = {12'h000, irq_pri_r, irq_en_r, req_flag_r};
        `SRT_OFF_BASE_DIV: rdata_nxt = {8'h00, `SRT_DIV_ONES | {4'h0, div_reload_r}};
        default:           rdata_nxt = 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // state without reset
  always_ff @(posedge clk) begin
    count_r    <= count_nxt;
    reload_r   <= reload_nxt;
    evt_prev_r <= evt_fall_r;
  end

  // ==========================================================================
  // state with reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctl_r        <= `SRT_CTL_RESET;
      req_flag_r   <= 1'b0;
      irq_en_r     <= 1'b0;
      irq_pri_r    <= 2'b00;
      div_reload_r <= 4'(`SRT_DIV_RESET);
      rdata_r      <= 16'h0000;
      timer_out_r  <= 1'b0;
    end else begin
      ctl_r        <= ctl_nxt;
      req_flag_r   <= req_flag_nxt;
      rdata_r      <= rdata_nxt;
      timer_out_r  <= ctl_nxt[`SRT_CTL_OUT_BIT];
      if (wr_irq) begin
        irq_en_r  <= req.wdata[`SRT_IRQ_EN_BIT];
        irq_pri_r <= req.wdata[`SRT_IRQ_PRI_MSB:`SRT_IRQ_PRI_LSB];
      end
      if (wr_div) begin
        div_reload_r <= req.wdata[3:0];
      end
    end
  end

  // ==========================================================================
  // outputs
  assign rdata     = rdata_r;
  assign timer_out = timer_out_r;
  // one assignment drives the whole struct, so it has a single driver
  assign irq = '{request:      req_flag_r,
                 enable:       irq_en_r,
                 priority_lvl: irq_pri_r,
                 vector:       `SRT_IRQ_VECTOR};

endmodule

// File: testbench/srt_timer_checker.sv
// checker on the reload timer ports
// assumes the synchronous active-low reset and the 0x62..0x6A register map
`timescale 1ns/1ps
module srt_timer_checker
  import srt_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // watched ports
  input wire srt_req_s    req,
  input wire logic [15:0] rdata,
  input wire logic        event_input,
  input wire logic        timer_out,
  input wire srt_irq_s    irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ========
  // assertions
  a_vector_fixed: assert property (irq.vector == 16'h001A)
    else $error("vector not 001A");
  a_ctl_ones: assert property (
    req.rd && req.addr == 8'h66 |=> rdata[15:8] == 8'h00 && rdata[6:4] == 3'b111)
    else $error("control fixed bits wrong");
  a_out_readback: assert property (
    req.rd && req.addr == 8'h66 |=> rdata[7] == $past(timer_out))
    else $error("output bit and pin differ");
  a_reset_state: assert property (
    $rose(resetn) |-> !timer_out && !irq.request && !irq.enable)
    else $error("reset state wrong");
  a_req_sticky: assert property (
    irq.request && !(req.wr && req.addr == 8'h68 && !req.wdata[0]) |=> irq.request)
    else $error("request dropped");
  a_enable_write: assert property (
    req.wr && req.addr == 8'h68 |=> irq.enable == $past(req.wdata[1]))
    else $error("enable not written");
  a_priority_write: assert property (
    req.wr && req.addr == 8'h68 |=> irq.priority_lvl == $past(req.wdata[3:2]))
    else $error("priority not written");
  a_out_write: assert property (
    req.wr && req.addr == 8'h66 |=> timer_out == $past(req.wdata[7]))
    else $error("output level not written");
  a_toggle_ovf: assert property ($rose(irq.request) |-> timer_out != $past(timer_out))
    else $error("no toggle on overflow");
endmodule
bind srt_timer srt_timer_checker chk_u (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
  .event_input(event_input), .timer_out(timer_out), .irq(irq));

// File: testbench/srt_evt_src.sv
// external event source in front of the timer
// assumes calls come just after a rising clock edge
`timescale 1ns/1ps
module srt_evt_src (
  // clock
  input  wire logic clk,
  // event line, driven low when idle
  output logic      event_input
);
  initial event_input = 1'b0;
  // each level holds w cycles, so sampling never misses a pulse
  task automatic pulses(input int n, input int w);
    for (int i = 0; i < n; i++) begin
      event_input <= 1'b1;
      repeat (w) @(posedge clk);
      event_input <= 1'b0;
      repeat (w) @(posedge clk);
    end
  endtask
endmodule

// File: testbench/srt_timer_tb_top.sv
// self-checking bench for the reload timer
// assumes a 40 MHz clock and the 0x62..0x6A register map
`timescale 1ns/1ps
module srt_timer_tb_top;
  import srt_pkg::*;
  logic        clk;
  logic        resetn;
  srt_req_s    req;
  logic [15:0] rdata;
  logic        event_input;
  logic        timer_out;
  srt_irq_s    irq;
  logic [15:0] v;
  logic [15:0] w;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          dv [6] = '{1, 2, 4, 8, 32, 256};
  // rows: write flag, address, data written or read back
  logic [24:0] rows [16] = '{25'h0660070, 25'h0680000, 25'h06A00F0, 25'h1621234,
    25'h0641234, 25'h164ABCD, 25'h0621234, 25'h064ABCD, 25'h1660085, 25'h06600F5,
    25'h166FF00, 25'h0660070, 25'h140FFFF, 25'h0400000, 25'h16A000F, 25'h06A00FF};

  srt_timer dut_u (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
    .event_input(event_input), .timer_out(timer_out), .irq(irq));
  srt_evt_src evt_u (.clk(clk), .event_input(event_input));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // a hang ends in the same report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      close_out();
    end
  end
  // ========
  // tasks
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rng(input string nm, input logic [15:0] seen, input int lo, input int hi);
    chk(nm, {15'h0, (seen >= lo && seen <= hi)}, 16'h0001);
  endtask
  // an idle edge after each access keeps strobes from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic wait_irq(input logic exp_out);
    for (int i = 0; i < 64 && irq.request !== 1'b1; i++)
      @(negedge clk);
    chk("request", {15'h0, irq.request}, 16'h0001);
    chk("toggle", {15'h0, timer_out}, {15'h0, exp_out});
    @(posedge clk);
  endtask
  // ========
  // sequence
  initial begin
    req = '0;
    resetn = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][24])
        wr(rows[i][23:16], rows[i][15:0]);
      else begin
        rd(rows[i][23:16], v);
        chk("row", v, rows[i][15:0]);
      end
    end
    wr(8'h62, 16'hFFFD);
    wr(8'h64, 16'h1000);
    wr(8'h66, 16'h0008);
    wait_irq(1'b1);
    wr(8'h66, 16'h0080);
    rd(8'h62, v);
    rng("reloaded", v, 16'h1000, 16'h1010);
    rd(8'h62, w);
    chk("halted", w, v);
    rd(8'h64, v);
    chk("reload_kept", v, 16'h1000);
    rd(8'h66, v);
    chk("ctl_out", v, 16'h00F0);
    wr(8'h68, 16'h000E);
    chk("irq", {12'h0, irq.priority_lvl, irq.enable, irq.request}, 16'h000E);
    chk("vector", irq.vector, 16'h001A);
    wr(8'h62, 16'hFFFE);
    wr(8'h64, 16'h0100);
    wr(8'h66, 16'h0088);
    wait_irq(1'b0);
    // the low reload keeps the next overflow far from this control write
    wr(8'h66, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      wr(8'h62, 16'h0000);
      wr(8'h66, {12'h0, 1'b1, k[2:0]});
      repeat (1024) @(posedge clk);
      wr(8'h66, 16'h0000);
      rd(8'h62, v);
      rng("tap", v, 1024 / dv[k] - 1, 1024 / dv[k] + 3);
    end
    for (int k = 6; k < 8; k++) begin
      wr(8'h62, 16'h0000);
      wr(8'h66, {12'h0, 1'b1, k[2:0]});
      evt_u.pulses(5, 2);
      repeat (4) @(posedge clk);
      wr(8'h66, 16'h0000);
      rd(8'h62, v);
      chk("events", v, 16'h0005);
    end
    wr(8'h66, 16'h0088);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h66, v);
    chk("ctl_reset", v, 16'h0070);
    chk("out_reset", {15'h0, timer_out}, 16'h0000);
    wr(8'h62, 16'h0000);
    wr(8'h66, 16'h0008);
    repeat (320) @(posedge clk);
    wr(8'h66, 16'h0000);
    rd(8'h62, v);
    rng("div16", v, 19, 22);
    close_out();
  end
endmodule
